// *** inband_pkg.sv ***
package inband_pkg;

  // pclk rate and integration period of the code detectors
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned INTEG_MS = 48;
  localparam int unsigned INTEG_CYCLES = INTEG_MS * (CLK_HZ / 1000);
  localparam int unsigned INTEG_W = 21;

  // a period passes when at most win_cnt >> MIS_SHIFT windows mismatch
  localparam int unsigned MIS_SHIFT = 2;

  // register indexes; the apb byte address is four times the index
  localparam logic [7:0] IDX_CTRL3 = 8'h03;
  localparam logic [7:0] IDX_LEN_CTRL = 8'h12;
  localparam logic [7:0] IDX_TX_PAT = 8'h13;
  localparam logic [7:0] IDX_UP_DEF = 8'h14;
  localparam logic [7:0] IDX_DN_DEF = 8'h15;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_MASK = 8'h21;
  localparam logic [7:0] IDX_LIVE = 8'h22;

  // field positions
  localparam int unsigned TX_LEN_HI = 7;
  localparam int unsigned TX_LEN_LO = 6;
  localparam int unsigned UP_LEN_MSB = 5;
  localparam int unsigned UP_LEN_LSB = 3;
  localparam int unsigned DN_LEN_MSB = 2;
  localparam int unsigned DN_LEN_LSB = 0;
  localparam int unsigned CTRL3_TX_EN_BIT = 1;
  localparam int unsigned CTRL3_FBIT_OFF_BIT = 0;
  localparam int unsigned STAT_UP_BIT = 7;
  localparam int unsigned STAT_DN_BIT = 6;

  // reset values
  localparam logic [7:0] RST_LEN_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_PAT = 8'h00;
  localparam logic [7:0] RST_DEF = 8'h00;
  localparam logic [1:0] RST_CTRL3 = 2'h0;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;

  typedef enum logic [1:0] {
    TXLEN_5 = 2'b00,
    TXLEN_6 = 2'b01,
    TXLEN_7 = 2'b10,
    TXLEN_8 = 2'b11
  } tx_len_e;

  typedef struct packed {
    logic [7:0] code;
    logic [2:0] len_sel;
  } det_cfg_s;

endpackage : inband_pkg

// *** inband_code_detect.sv ***
`timescale 1ns/1ps
`default_nettype none

module inband_code_detect (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // received line bits
  input wire logic bit_valid,
  input wire logic bit_in,
  // code definition and integration timing
  input wire inband_pkg::det_cfg_s cfg,
  input wire logic period_end,
  // one-cycle pulse: code held for a whole period
  output logic hit,
  // level: last period passed
  output logic present
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [7:0] hist;
  logic [7:0] next_hist;
  logic [3:0] len;
  logic win_ok;
  logic [inband_pkg::INTEG_W-1:0] win_cnt;
  logic [inband_pkg::INTEG_W-1:0] mis_cnt;

  // true when the last l bits equal some rotation of the first l code bits;
  // rotations make the check independent of where the code phase lands
  function automatic logic rot_match(input logic [7:0] w, input logic [7:0] c,
                                     input logic [3:0] l);
    logic found;
    logic ok;
    int k;
    found = 1'b0;
    for (int r = 0; r < 8; r++) begin
      ok = 1'b0;
      if (r < int'(l)) begin
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
          if (i < int'(l)) begin
            k = i + r;
            if (k >= int'(l)) begin
              k = k - int'(l);
            end
            if (w[int'(l) - 1 - i] != c[7 - k]) begin
              ok = 1'b0;
            end
          end
        end
      end
      found = found | ok;
    end
    return found;
  endfunction : rot_match

  assign len = {1'b0, cfg.len_sel} + 4'd1;
  assign next_hist = {hist[6:0], bit_in};
  // code msb first, tail bits ignored
  assign win_ok = rot_match(next_hist, cfg.code, len);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist <= 8'h00;
    end else if (bit_valid) begin
      hist <= next_hist;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt <= '0;
      mis_cnt <= '0;
    end else if (period_end) begin
      win_cnt <= '0;
      mis_cnt <= '0;
    end else if (bit_valid) begin
      win_cnt <= win_cnt + 1'b1;
      if (!win_ok) begin
        mis_cnt <= mis_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit <= 1'b0;
      present <= 1'b0;
    end else begin
      hit <= period_end && (win_cnt != '0) && (mis_cnt <= (win_cnt >> inband_pkg::MIS_SHIFT));
      if (period_end) begin
        present <= (win_cnt != '0) && (mis_cnt <= (win_cnt >> inband_pkg::MIS_SHIFT));
      end
    end
  end

  a_hit_at_period: assert property (hit |-> $past(period_end) && present)
    else $error("detector hit outside a period end");

  a_quiet_no_hit: assert property (period_end && win_cnt == '0 |=> !hit && !present)
    else $error("detector hit without received bits");

endmodule : inband_code_detect

`default_nettype wire

// *** inband_loop_code_gen_detect.sv ***
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - generate and detect repeating patterns of one to eight bits
// - tx length from length control bits 7:6, pattern from tx pattern register
// - tx length 00=5, 01=6/3, 10=7, 11=8/4/2/1 bits
// - pattern sent continuously while control-3 bit 1 is set
// - framing bit overwrites pattern each 193 bits unless insertion is off
// - pattern bit 7 goes first, then lower bits descending
// - unused low pattern bits are ignored for lengths 5, 6, 7
// - two independent detectors, loop-up and loop-down, each own definition
// - up length from bits 5:3, down length from bits 2:0
// - receive length equals field value plus one
// - detect framed or unframed input with error rate up to 1e-2
// - after about 48 ms of code set status bit 7 (up) or 6 (down)
// - definition bit 7 is first; bits past length are don't care
module inband_loop_code_gen_detect #(
  parameter int unsigned integ_cycles = inband_pkg::INTEG_CYCLES
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit bit stream from the formatter
  input wire logic tx_bit_req,
  input wire logic tx_payload_bit,
  input wire logic tx_fbit_pos,
  input wire logic tx_fbit,
  output logic tx_line_bit,
  output logic tx_line_strobe,
  // received line bits
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  // interrupt
  output logic irq
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [7:0] len_ctrl;
  logic [7:0] tx_pat;
  logic [7:0] up_def;
  logic [7:0] dn_def;
  logic [1:0] ctrl3;
  logic [7:0] status;
  logic [7:0] mask;

  logic setup;
  logic wr_fire;
  logic mapped;
  logic [7:0] idx;
  logic [7:0] rd_val;

  inband_pkg::tx_len_e tx_len_mode;
  logic [3:0] tx_len;
  logic [2:0] tx_phase;
  logic tx_last;
  logic pat_bit;
  logic loop_en;
  logic fbit_off;

  logic [inband_pkg::INTEG_W-1:0] per_cnt;
  logic period_end;
  inband_pkg::det_cfg_s cfg [2];
  logic [1:0] hit;
  logic [1:0] present;
  logic [7:0] status_set;
  logic status_wr;
  logic irq_src;

  // apb slave
  assign setup = psel & ~penable;
  assign idx = paddr[9:2];
  // an unmapped access answers with pslverr and writes nothing
  assign wr_fire = psel & penable & pwrite & pready & ~pslverr;

  always_comb begin
    rd_val = 8'h00;
    mapped = 1'b1;
    if (idx == inband_pkg::IDX_CTRL3) begin
      rd_val = {6'h00, ctrl3};
    end else if (idx == inband_pkg::IDX_LEN_CTRL) begin
      rd_val = len_ctrl;
    end else if (idx == inband_pkg::IDX_TX_PAT) begin
      rd_val = tx_pat;
    end else if (idx == inband_pkg::IDX_UP_DEF) begin
      rd_val = up_def;
    end else if (idx == inband_pkg::IDX_DN_DEF) begin
      rd_val = dn_def;
    end else if (idx == inband_pkg::IDX_STATUS) begin
      rd_val = status;
    end else if (idx == inband_pkg::IDX_MASK) begin
      rd_val = mask;
    end else if (idx == inband_pkg::IDX_LIVE) begin
      // up presence sits above down presence, as in the status layout
      rd_val = {present[0], present[1], 3'h0, tx_phase};
    end else begin
      mapped = 1'b0;
    end
  end

  // one access cycle: data and ready are prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= {24'h00_0000, rd_val};
      end
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_ctrl <= inband_pkg::RST_LEN_CTRL;
      tx_pat <= inband_pkg::RST_TX_PAT;
      up_def <= inband_pkg::RST_DEF;
      dn_def <= inband_pkg::RST_DEF;
      ctrl3 <= inband_pkg::RST_CTRL3;
      mask <= inband_pkg::RST_MASK;
    end else if (wr_fire) begin
      if (idx == inband_pkg::IDX_LEN_CTRL) begin
        len_ctrl <= pwdata[7:0];
      end else if (idx == inband_pkg::IDX_TX_PAT) begin
        tx_pat <= pwdata[7:0];
      end else if (idx == inband_pkg::IDX_UP_DEF) begin
        up_def <= pwdata[7:0];
      end else if (idx == inband_pkg::IDX_DN_DEF) begin
        dn_def <= pwdata[7:0];
      end else if (idx == inband_pkg::IDX_CTRL3) begin
        ctrl3 <= pwdata[1:0];
      end else if (idx == inband_pkg::IDX_MASK) begin
        mask <= pwdata[7:0];
      end
    end
  end

  // transmit code generator
  assign loop_en = ctrl3[inband_pkg::CTRL3_TX_EN_BIT];
  assign fbit_off = ctrl3[inband_pkg::CTRL3_FBIT_OFF_BIT];
  assign tx_len_mode = inband_pkg::tx_len_e'(len_ctrl[inband_pkg::TX_LEN_HI:inband_pkg::TX_LEN_LO]);

  // short codes repeat inside 6 or 8
  always_comb begin
    case (tx_len_mode)
      inband_pkg::TXLEN_5: tx_len = 4'd5;
      inband_pkg::TXLEN_6: tx_len = 4'd6;
      inband_pkg::TXLEN_7: tx_len = 4'd7;
      default: tx_len = 4'd8;
    endcase
  end

  assign pat_bit = tx_pat[3'd7 - tx_phase];
  assign tx_last = ({1'b0, tx_phase} >= (tx_len - 4'd1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_phase <= 3'd0;
      tx_line_bit <= 1'b0;
      tx_line_strobe <= 1'b0;
    end else begin
      tx_line_strobe <= tx_bit_req;
      if (!loop_en) begin
        tx_phase <= 3'd0;
      end
      if (tx_bit_req) begin
        if (!loop_en) begin
          tx_line_bit <= tx_payload_bit;
        end else begin
          if (tx_fbit_pos && !fbit_off) begin
            tx_line_bit <= tx_fbit;
          end else begin
            tx_line_bit <= pat_bit;
          end
          // the overwritten bit still consumes a pattern slot
          tx_phase <= tx_last ? 3'd0 : tx_phase + 3'd1;
        end
      end
    end
  end

  // receive code detectors
  // shared integration timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt <= '0;
      period_end <= 1'b0;
    end else if (per_cnt == '0) begin
      per_cnt <= inband_pkg::INTEG_W'(integ_cycles - 1);
      period_end <= 1'b1;
    end else begin
      per_cnt <= per_cnt - 1'b1;
      period_end <= 1'b0;
    end
  end

  assign cfg[0] = '{code: up_def,
                    len_sel: len_ctrl[inband_pkg::UP_LEN_MSB:inband_pkg::UP_LEN_LSB]};
  assign cfg[1] = '{code: dn_def,
                    len_sel: len_ctrl[inband_pkg::DN_LEN_MSB:inband_pkg::DN_LEN_LSB]};

  for (genvar g = 0; g < 2; g++) begin : g_det
    inband_code_detect u_det (
      .pclk(pclk),
      .presetn(presetn),
      .bit_valid(rx_bit_valid),
      .bit_in(rx_bit),
      .cfg(cfg[g]),
      .period_end(period_end),
      .hit(hit[g]),
      .present(present[g])
    );
  end

  // status and interrupt
  always_comb begin
    status_set = 8'h00;
    status_set[inband_pkg::STAT_UP_BIT] = hit[0];
    status_set[inband_pkg::STAT_DN_BIT] = hit[1];
  end

  assign status_wr = wr_fire && (idx == inband_pkg::IDX_STATUS);

  // sticky, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= inband_pkg::RST_STATUS;
    end else begin
      status <= (status & ~(status_wr ? pwdata[7:0] : 8'h00)) | status_set;
    end
  end

  assign irq_src = |(status & mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_src;
    end
  end

  // checks
  sequence s_dn_hit_masked;
    hit[1] ##1 mask[inband_pkg::STAT_DN_BIT];
  endsequence

  a_first_bit_msb: assert property ($rose(loop_en) |-> tx_phase == 3'd0)
    else $error("pattern did not restart at bit 7");

  a_pattern_bits: assert property (
    tx_bit_req && loop_en && !(tx_fbit_pos && !fbit_off)
    |=> tx_line_strobe && tx_line_bit == $past(pat_bit))
    else $error("pattern bit not sent");

  a_tx_len_wrap: assert property (
    tx_bit_req && loop_en && tx_phase == 3'(tx_len - 4'd1) |=> tx_phase == 3'd0)
    else $error("pattern length wrap wrong");

  a_short_len_phase: assert property (
    loop_en && tx_len == 4'd5 && $past(tx_len) == 4'd5 && $past(tx_phase) < 3'd5
    |-> tx_phase < 3'd5)
    else $error("unused pattern bit reached at length 5");

  a_fbit_overwrite: assert property (
    tx_bit_req && loop_en && tx_fbit_pos && !fbit_off
    |=> tx_line_strobe && tx_line_bit == $past(tx_fbit))
    else $error("framing bit not inserted");

  a_payload_off: assert property (
    tx_bit_req && !loop_en |=> tx_line_bit == $past(tx_payload_bit))
    else $error("payload not resumed");

  a_set_beats_clear: assert property (hit[0] |=> status[inband_pkg::STAT_UP_BIT])
    else $error("loop-up status lost");

  a_status_sticky: assert property (
    status[inband_pkg::STAT_DN_BIT] && !(status_wr && pwdata[inband_pkg::STAT_DN_BIT])
    |=> status[inband_pkg::STAT_DN_BIT])
    else $error("loop-down status not sticky");

  a_irq_raise: assert property (s_dn_hit_masked |=> irq)
    else $error("interrupt not raised");

endmodule : inband_loop_code_gen_detect

`default_nettype wire

// *** line_peer.sv ***
`timescale 1ns/1ps
`default_nettype none

// far-end unit: repeats a loop code on the receive line, one bit every 4 pclk
module line_peer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // code to send
  input wire logic sending,
  input wire logic err_on,
  input wire logic [7:0] code,
  input wire logic [3:0] len,
  // line toward the receiver
  output logic rx_bit_valid,
  output logic rx_bit
);
  int div;
  int ph;
  int nbit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 0;
      ph <= 0;
      nbit <= 0;
      rx_bit_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else begin
      div <= (div == 3) ? 0 : div + 1;
      rx_bit_valid <= 1'b0;
      if (!sending) begin
        // idle line must not hold a stale bit
        rx_bit <= ~rx_bit;
        ph <= 0;
      end else if (div == 3) begin
        rx_bit_valid <= 1'b1;
        nbit <= (nbit == 99) ? 0 : nbit + 1;
        ph <= (ph + 1 == int'(len)) ? 0 : ph + 1;
        rx_bit <= code[7 - ph] ^ (err_on && nbit == 99);
      end
    end
  end
endmodule : line_peer
`default_nettype wire

// *** inband_loop_code_gen_detect_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module inband_loop_code_gen_detect_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, tx_line_bit, tx_line_strobe, rx_bit_valid, rx_bit, irq;
  logic tx_bit_req = 0, tx_payload_bit = 0, tx_fbit_pos = 0, tx_fbit = 0;
  logic sending = 0, err_on = 0, err, e;
  logic [7:0] code = '0, rd;
  logic [3:0] len = 4'h8;
  logic [1:0] tf [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [7:0] tp [4] = '{8'h87, 8'h6C, 8'hB3, 8'hA5};
  logic [7:0] ri [6];
  int tl [4] = '{5, 6, 7, 8};
  int fail_count = 0, num_checks = 0, cyc = 0;

  always #12.5 pclk = ~pclk;

  inband_loop_code_gen_detect #(.integ_cycles(2000)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_req(tx_bit_req), .tx_payload_bit(tx_payload_bit), .tx_fbit_pos(tx_fbit_pos),
    .tx_fbit(tx_fbit), .tx_line_bit(tx_line_bit), .tx_line_strobe(tx_line_strobe),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .irq(irq));

  line_peer peer_u (.pclk(pclk), .presetn(presetn), .sending(sending), .err_on(err_on),
    .code(code), .len(len), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // pready is awaited with no assumed latency
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic txr(input logic fp, input logic fb, input logic pay, input logic ex);
    @(posedge pclk);
    tx_bit_req <= 1'b1;
    tx_fbit_pos <= fp;
    tx_fbit <= fb;
    tx_payload_bit <= pay;
    @(posedge pclk);
    tx_bit_req <= 1'b0;
    #1;
    chk({7'h00, tx_line_strobe}, 8'h01);
    chk({7'h00, tx_line_bit}, {7'h00, ex});
  endtask : txr

  task automatic rx_run(input logic [7:0] c, input logic [3:0] l, input logic eo,
                        input logic [7:0] lv);
    code <= c;
    len <= l;
    err_on <= eo;
    sending <= 1'b1;
    repeat (5000) @(posedge pclk);
    // live presence is read while the code is still arriving
    apb(1'b0, inband_pkg::IDX_LIVE, 8'h00);
    chk(rd, lv);
    sending <= 1'b0;
    repeat (2500) @(posedge pclk);
  endtask : rx_run

  task automatic irq_is(input logic v);
    repeat (3) @(posedge pclk);
    #1;
    chk({7'h00, irq}, {7'h00, v});
  endtask : irq_is

  initial begin
    ri = '{inband_pkg::IDX_LEN_CTRL, inband_pkg::IDX_TX_PAT, inband_pkg::IDX_UP_DEF,
      inband_pkg::IDX_DN_DEF, inband_pkg::IDX_STATUS, inband_pkg::IDX_MASK};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ri[i]) begin
      apb(1'b0, ri[i], 8'h00);
      chk(rd, 8'h00);
    end
    apb(1'b1, 8'h7F, 8'h5A);
    chk({7'h00, err}, 8'h01);
    chk(rd, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, inband_pkg::IDX_CTRL3, 8'h00);
      apb(1'b1, inband_pkg::IDX_LEN_CTRL, {tf[i], 6'h00});
      apb(1'b1, inband_pkg::IDX_TX_PAT, tp[i]);
      apb(1'b1, inband_pkg::IDX_CTRL3, 8'h02);
      for (int k = 0; k <= 2 * tl[i]; k++) begin
        e = tp[i][7 - (k % tl[i])];
        // framing slot mid-run overrides one pattern bit
        if (k == tl[i]) txr(1'b1, ~e, ~e, ~e);
        else txr(1'b0, ~e, ~e, e);
      end
    end
    apb(1'b1, inband_pkg::IDX_CTRL3, 8'h00);
    apb(1'b1, inband_pkg::IDX_CTRL3, 8'h03);
    txr(1'b1, 1'b0, 1'b0, 1'b1);
    apb(1'b1, inband_pkg::IDX_CTRL3, 8'h00);
    txr(1'b0, 1'b0, 1'b1, 1'b1);
    txr(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test transmit done");
    apb(1'b1, inband_pkg::IDX_LEN_CTRL, 8'h27);
    apb(1'b1, inband_pkg::IDX_UP_DEF, 8'h87);
    apb(1'b1, inband_pkg::IDX_DN_DEF, 8'hF0);
    apb(1'b0, inband_pkg::IDX_UP_DEF, 8'h00);
    chk(rd, 8'h87);
    rx_run(8'h80, 4'h5, 1'b0, 8'h80);
    // host poll sees only the up code
    apb(1'b0, inband_pkg::IDX_STATUS, 8'h00);
    chk(rd, 8'h80);
    irq_is(1'b0);
    apb(1'b1, inband_pkg::IDX_MASK, 8'h80);
    irq_is(1'b1);
    apb(1'b1, inband_pkg::IDX_STATUS, 8'h80);
    irq_is(1'b0);
    apb(1'b0, inband_pkg::IDX_STATUS, 8'h00);
    chk(rd, 8'h00);
    apb(1'b1, inband_pkg::IDX_MASK, 8'hC0);
    rx_run(8'hF0, 4'h8, 1'b1, 8'h40);
    apb(1'b0, inband_pkg::IDX_STATUS, 8'h00);
    chk(rd, 8'h40);
    irq_is(1'b1);
    apb(1'b1, inband_pkg::IDX_MASK, 8'h80);
    irq_is(1'b0);
    apb(1'b1, inband_pkg::IDX_MASK, 8'hC0);
    irq_is(1'b1);
    apb(1'b1, inband_pkg::IDX_STATUS, 8'hC0);
    irq_is(1'b0);
    $display("test receive done");
    final_report();
  end
endmodule : inband_loop_code_gen_detect_bench
`default_nettype wire
